/* File: logic/serial_ports_regs.vh */
// register offsets, field positions and reset values for the serial port block
`ifndef SERIAL_PORTS_REGS_VH
`define SERIAL_PORTS_REGS_VH

// register offsets on the plain register port
`define REG_COMMAND 4'h0
`define REG_BAUD 4'h1
`define REG_GP_MODE 4'h2
`define REG_GPIO_OUT 4'h3
`define REG_GPIO_OE 4'h4
`define REG_GPIO_IN 4'h5
`define REG_DEBUG_SEL 4'h6
`define REG_STATUS0 4'h8
`define REG_STATUS1 4'h9
`define REG_STATUS2 4'hA
`define REG_DATA0 4'hC
`define REG_DATA1 4'hD
`define REG_DATA2 4'hE

// command register fields, one bit per port from each base
`define CMD_TX_EN_LSB 0
`define CMD_RTS_LSB 3
`define CMD_DTR_BIT 6
`define CMD_ENH_LSB 7

// general-purpose mode register field
`define GP_MODE_PORT0_GPIO_BIT 1

// reset values
`define COMMAND_RESET 10'h000
`define BAUD_RESET 16'h0036
`define GP_MODE_RESET 8'h00
`define GPIO_OUT_RESET 5'h1F
`define GPIO_OE_RESET 5'h00
`define PIN_OUT_RESET 5'h1F
`define PIN_OE_NORMAL 5'h06

// frame timing counts
`define SAMPLE_MID 4'h7
`define LAST_OVS 4'hF
`define LAST_TX_BIT 4'h9
`define STOP_BIT 4'h9

`endif

/* File: logic/serial_ports_debug_mux.v */
// three asynchronous serial ports with modem lines, gpio reuse and debug pin mux
//
// Behaviour
// [R1] in debug selection the port 1 clear-to-send pin feeds the debug clock input
// [R2] port 0 peer-ready pin level is captured into port 0 status
// [R3] general mode bit 1 turns five port 0 modem pins into gpio
// [R4] port 0 terminal-ready follows a command bit, deasserted after reset
// [R5] request-to-send of ports 0 and 1 follow command bits, deasserted after reset
// [R6] each port receives characters at the programmed rate into its receive register
// [R7] each port serializes its transmit register as 8N1, idle high after reset
// [R8] strap sampled in reset: high keeps port 1 serial, low selects debug port
// [R9] in debug selection port 1 transmit pin carries debug transmit data, idle after reset
// [R10] enhanced mode: partner supplies bit clocks, transmit bits follow external transmit clock
// [R11] enhanced mode: received bits sampled on external receive clock
// [R12] transmit starts only with transmit enable set and clear-to-send asserted
// [R13] receiver finds start on falling edge, samples bit centres on 16x tick
`timescale 1ns/100ps
`default_nettype none
`include "serial_ports_regs.vh"

module serial_ports_debug_mux (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire [3:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [15:0] regRdData,
  input wire port0_peer_ready_n,
  output wire port0_peer_ready_n_out,
  output wire port0_peer_ready_n_oe,
  input wire port0_terminal_ready_n,
  output wire port0_terminal_ready_n_out,
  output wire port0_terminal_ready_n_oe,
  input wire port0_send_request_n,
  output wire port0_send_request_n_out,
  output wire port0_send_request_n_oe,
  input wire port0_serial_in,
  output wire port0_serial_in_out,
  output wire port0_serial_in_oe,
  input wire port0_clear_to_send_n,
  output wire port0_clear_to_send_n_out,
  output wire port0_clear_to_send_n_oe,
  output wire port0_serial_out,
  input wire port1_serial_in,
  output reg port1_serial_out,
  input wire port1_clear_to_send_n,
  output reg port1_send_request_n,
  input wire port2_serial_in,
  output wire port2_serial_out,
  input wire ext_transmit_bit_clock,
  input wire ext_receive_bit_clock,
  input wire debugStrap,
  output reg debug_port_clock_in,
  output reg debug_port_serial_in,
  input wire debug_port_serial_out
);

  reg [10:0] syncA_q;
  reg [10:0] syncB_q;
  reg [1:0] clkPrev_q;
  reg [9:0] command_q;
  reg [15:0] baud_q;
  reg [7:0] gpMode_q;
  reg [4:0] gpioOut_q;
  reg [4:0] gpioOe_q;
  reg debugSel_q;
  reg peerReady_q;
  reg [4:0] pinOut_q;
  reg [4:0] pinOe_q;
  reg [15:0] baudCnt_q;
  wire [10:0] rawIn;
  wire port0GpioMode;
  wire ovsTick;
  wire tclkRise;
  wire rclkRise;
  wire [2:0] rxLine;
  wire [2:0] ctsOk;
  wire [2:0] txLine;
  wire [23:0] rxDataAll;
  wire [17:0] statAll;

  // every pin from outside, bit 0..4 in port 0 gpio order
  assign rawIn = {debugStrap, ext_receive_bit_clock, ext_transmit_bit_clock,
                  port2_serial_in, port1_clear_to_send_n, port1_serial_in,
                  port0_clear_to_send_n, port0_serial_in, port0_send_request_n,
                  port0_terminal_ready_n, port0_peer_ready_n};

  // two-stage synchronisers, left free of reset so the strap is seen in reset
  always @(posedge mclk) begin
    if (ce) begin
      syncA_q <= rawIn;
      syncB_q <= syncA_q;
    end
  end

  // edge detection of the external bit clocks
  always @(posedge mclk) begin
    if (rst) begin
      clkPrev_q <= 2'h0;
    end else if (ce) begin
      clkPrev_q <= syncB_q[9:8];
    end
  end

  assign tclkRise = syncB_q[8] & ~clkPrev_q[0]; // [R10]
  assign rclkRise = syncB_q[9] & ~clkPrev_q[1]; // [R11]

  // software-written registers
  always @(posedge mclk) begin
    if (rst) begin
      command_q <= `COMMAND_RESET;
      baud_q <= `BAUD_RESET;
      gpMode_q <= `GP_MODE_RESET;
      gpioOut_q <= `GPIO_OUT_RESET;
      gpioOe_q <= `GPIO_OE_RESET;
    end else if (ce && regWr) begin
      case (regAddr)
        `REG_COMMAND: command_q <= regWrData[9:0];
        `REG_BAUD: baud_q <= regWrData;
        `REG_GP_MODE: gpMode_q <= regWrData[7:0];
        `REG_GPIO_OUT: gpioOut_q <= regWrData[4:0];
        `REG_GPIO_OE: gpioOe_q <= regWrData[4:0];
        default: ;
      endcase
    end
  end

  // strap caught while reset is held, kept afterwards
  always @(posedge mclk) begin
    if (rst) begin
      debugSel_q <= ~syncB_q[10]; // [R8]
    end
  end

  // peer-ready level captured for the status register
  always @(posedge mclk) begin
    if (rst) begin
      peerReady_q <= 1'b1;
    end else if (ce) begin
      peerReady_q <= syncB_q[0]; // [R2]
    end
  end

  assign port0GpioMode = gpMode_q[`GP_MODE_PORT0_GPIO_BIT];

  // port 0 modem pins: modem role or general-purpose role
  always @(posedge mclk) begin
    if (rst) begin
      pinOut_q <= `PIN_OUT_RESET;
      pinOe_q <= `PIN_OE_NORMAL;
    end else if (ce) begin
      if (port0GpioMode) begin
        pinOut_q <= gpioOut_q; // [R3]
        pinOe_q <= gpioOe_q; // [R3]
      end else begin
        pinOut_q <= {1'b1, 1'b1, ~command_q[`CMD_RTS_LSB], // [R5]
                     ~command_q[`CMD_DTR_BIT], 1'b1}; // [R4]
        pinOe_q <= `PIN_OE_NORMAL;
      end
    end
  end

  assign port0_peer_ready_n_out = pinOut_q[0];
  assign port0_peer_ready_n_oe = pinOe_q[0];
  assign port0_terminal_ready_n_out = pinOut_q[1];
  assign port0_terminal_ready_n_oe = pinOe_q[1];
  assign port0_send_request_n_out = pinOut_q[2];
  assign port0_send_request_n_oe = pinOe_q[2];
  assign port0_serial_in_out = pinOut_q[3];
  assign port0_serial_in_oe = pinOe_q[3];
  assign port0_clear_to_send_n_out = pinOut_q[4];
  assign port0_clear_to_send_n_oe = pinOe_q[4];

  // port 1 pins shared with the debug port
  always @(posedge mclk) begin
    if (rst) begin
      port1_serial_out <= 1'b1;
      port1_send_request_n <= 1'b1;
      debug_port_clock_in <= 1'b0;
      debug_port_serial_in <= 1'b1;
    end else if (ce) begin
      port1_serial_out <= debugSel_q ? debug_port_serial_out : txLine[1]; // [R9] [R7]
      port1_send_request_n <= ~command_q[`CMD_RTS_LSB + 1]; // [R5]
      debug_port_clock_in <= debugSel_q & syncB_q[6]; // [R1]
      debug_port_serial_in <= debugSel_q ? syncB_q[5] : 1'b1; // [R8]
    end
  end

  // receive lines idle high when the pin serves another role
  assign rxLine = {syncB_q[7], debugSel_q | syncB_q[5], port0GpioMode | syncB_q[3]};
  // clear-to-send per port; port 2 has no such pin
  assign ctsOk = {1'b1, ~debugSel_q & ~syncB_q[6], port0GpioMode | ~syncB_q[4]};

  // shared 16x oversample tick, period of baud_q cycles
  always @(posedge mclk) begin
    if (rst) begin
      baudCnt_q <= 16'h0000;
    end else if (ce) begin
      if (ovsTick) begin
        baudCnt_q <= (baud_q == 16'h0000) ? 16'h0000 : baud_q - 16'h0001;
      end else begin
        baudCnt_q <= baudCnt_q - 16'h0001;
      end
    end
  end

  assign ovsTick = (baudCnt_q == 16'h0000);

  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : port
      localparam [3:0] DATA_ADDR = (p == 0) ? `REG_DATA0 : ((p == 1) ? `REG_DATA1 : `REG_DATA2);
      reg [9:0] txShift_q;
      reg [3:0] txBits_q;
      reg [3:0] txOvs_q;
      reg txBusy_q;
      reg [7:0] txHold_q;
      reg txPending_q;
      reg [7:0] rxShift_q;
      reg [7:0] rxData_q;
      reg rxFull_q;
      reg rxBusy_q;
      reg [3:0] rxOvs_q;
      reg [3:0] rxBit_q;
      reg rxPrev_q;
      wire enh;
      wire dataWr;
      wire dataRd;
      wire txStart;
      wire txStep;
      wire rxIn;
      wire rxSample;
      wire rxDeliver;
      wire rxBegin;

      assign enh = command_q[`CMD_ENH_LSB + p];
      assign dataWr = ce & regWr & (regAddr == DATA_ADDR);
      assign dataRd = ce & regRd & (regAddr == DATA_ADDR);
      assign txStart = ~txBusy_q & txPending_q & command_q[`CMD_TX_EN_LSB + p] & ctsOk[p]; // [R12]
      assign txStep = txBusy_q & (enh ? tclkRise : (ovsTick & (txOvs_q == `LAST_OVS))); // [R10]
      assign rxIn = rxLine[p];
      assign rxSample = rxBusy_q & (enh ? rclkRise : // [R11]
                        (ovsTick & (rxOvs_q == `SAMPLE_MID))); // [R13]
      assign rxDeliver = rxSample & (rxBit_q == `STOP_BIT) & rxIn;
      assign rxBegin = ~rxBusy_q & (enh ? (rclkRise & ~rxIn) : (rxPrev_q & ~rxIn)); // [R13]

      // transmit holding register and 8N1 serializer
      always @(posedge mclk) begin
        if (rst) begin
          txShift_q <= 10'h3FF;
          txBits_q <= 4'h0;
          txOvs_q <= 4'h0;
          txBusy_q <= 1'b0;
          txHold_q <= 8'h00;
          txPending_q <= 1'b0;
        end else if (ce) begin
          if (dataWr) begin
            txHold_q <= regWrData[7:0];
            txPending_q <= 1'b1;
          end else if (txStart) begin
            txPending_q <= 1'b0;
          end
          if (txStart) begin
            txShift_q <= {1'b1, txHold_q, 1'b0}; // [R7]
            txBusy_q <= 1'b1;
            txBits_q <= 4'h0;
            txOvs_q <= 4'h0;
          end else if (txBusy_q) begin
            if (!enh && ovsTick) begin
              txOvs_q <= txOvs_q + 4'h1;
            end
            if (txStep) begin
              txShift_q <= {1'b1, txShift_q[9:1]}; // [R7]
              txBits_q <= txBits_q + 4'h1;
              if (txBits_q == `LAST_TX_BIT) begin
                txBusy_q <= 1'b0;
              end
            end
          end
        end
      end

      // receiver: start search, bit sampling, character hand-over
      always @(posedge mclk) begin
        if (rst) begin
          rxShift_q <= 8'h00;
          rxData_q <= 8'h00;
          rxFull_q <= 1'b0;
          rxBusy_q <= 1'b0;
          rxOvs_q <= 4'h0;
          rxBit_q <= 4'h0;
          rxPrev_q <= 1'b1;
        end else if (ce) begin
          rxPrev_q <= rxIn;
          if (rxDeliver) begin
            rxData_q <= rxShift_q; // [R6]
            rxFull_q <= 1'b1;
          end else if (dataRd) begin
            rxFull_q <= 1'b0;
          end
          if (rxBegin) begin
            rxBusy_q <= 1'b1;
            rxOvs_q <= 4'h0;
            rxBit_q <= enh ? 4'h1 : 4'h0;
          end else if (rxBusy_q) begin
            if (!enh && ovsTick) begin
              rxOvs_q <= rxOvs_q + 4'h1;
            end
            if (rxSample) begin
              rxBit_q <= rxBit_q + 4'h1;
              if (rxBit_q == 4'h0) begin
                rxBusy_q <= ~rxIn; // [R13]
              end else if (rxBit_q == `STOP_BIT) begin
                rxBusy_q <= 1'b0;
              end else begin
                rxShift_q <= {rxIn, rxShift_q[7:1]}; // [R6]
              end
            end
          end
        end
      end

      assign txLine[p] = txShift_q[0];
      assign rxDataAll[p * 8 +: 8] = rxData_q;
      // status: peer ready, clear, busy, empty, full
      assign statAll[p * 6 +: 6] = {(p == 0) ? peerReady_q : 1'b0, ctsOk[p], txBusy_q,
                                    ~txPending_q, rxFull_q};
    end
  endgenerate

  assign port0_serial_out = txLine[0];
  assign port2_serial_out = txLine[2];

  // read data registered, valid in the cycle after the strobe
  always @(posedge mclk) begin
    if (rst) begin
      regRdData <= 16'h0000;
    end else if (ce) begin
      if (regRd) begin
        case (regAddr)
          `REG_COMMAND: regRdData <= {6'h00, command_q};
          `REG_BAUD: regRdData <= baud_q;
          `REG_GP_MODE: regRdData <= {8'h00, gpMode_q};
          `REG_GPIO_OUT: regRdData <= {11'h000, gpioOut_q};
          `REG_GPIO_OE: regRdData <= {11'h000, gpioOe_q};
          `REG_GPIO_IN: regRdData <= {11'h000, syncB_q[4:0]}; // [R3]
          `REG_DEBUG_SEL: regRdData <= {15'h0000, debugSel_q};
          `REG_STATUS0: regRdData <= {10'h000, statAll[5:0]}; // [R2]
          `REG_STATUS1: regRdData <= {10'h000, statAll[11:6]};
          `REG_STATUS2: regRdData <= {10'h000, statAll[17:12]};
          `REG_DATA0: regRdData <= {8'h00, rxDataAll[7:0]};
          `REG_DATA1: regRdData <= {8'h00, rxDataAll[15:8]};
          `REG_DATA2: regRdData <= {8'h00, rxDataAll[23:16]};
          default: regRdData <= 16'h0000;
        endcase
      end else begin
        regRdData <= 16'h0000;
      end
    end
  end

endmodule // serial_ports_debug_mux

`default_nettype wire

/* File: dv/serial_ports_chk.sv */
// pin-level assertions for the serial port block
`timescale 1ns/100ps
`default_nettype none
module serial_ports_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdData,
  input wire logic port0_terminal_ready_n_out,
  input wire logic port0_send_request_n_out,
  input wire logic port0_serial_out,
  input wire logic port1_serial_in,
  input wire logic port1_serial_out,
  input wire logic port1_clear_to_send_n,
  input wire logic port1_send_request_n,
  input wire logic port2_serial_out,
  input wire logic debugStrap,
  input wire logic debug_port_clock_in,
  input wire logic debug_port_serial_in,
  input wire logic debug_port_serial_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic dbgSel;
  // strap choice kept from the last reset edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      dbgSel <= !debugStrap;
    end
  end
  sequence s_hold;
    $stable(port0_serial_out) [*8];
  endsequence
  sequence s_cmdWr;
    regWr && regAddr == 4'h0;
  endsequence
  a_idle_after_reset: assert property ($fell(rst) |-> port0_serial_out
    && port1_serial_out && port2_serial_out && port1_send_request_n
    && port0_terminal_ready_n_out && port0_send_request_n_out) else $error("idle levels wrong");
  a_rts_follow: assert property (s_cmdWr |-> ##2
    port1_send_request_n == !$past(regWrData[4], 2)) else $error("rts not following cmd");
  a_bit_hold: assert property ($changed(port0_serial_out) |=> s_hold)
    else $error("serial bit too short");
  a_dbg_clock: assert property (dbgSel && !$past(rst, 3) |->
    debug_port_clock_in == $past(port1_clear_to_send_n, 3)) else $error("debug clock wrong");
  a_dbg_rx: assert property (dbgSel && !$past(rst, 3) |->
    debug_port_serial_in == $past(port1_serial_in, 3)) else $error("debug rx wrong");
  a_dbg_tx: assert property (dbgSel && !$past(rst) |->
    port1_serial_out == $past(debug_port_serial_out)) else $error("debug tx wrong");
  a_norm_dbg_idle: assert property (!dbgSel |->
    !debug_port_clock_in && debug_port_serial_in) else $error("debug pins active");
  a_read_pulse: assert property (!$past(regRd) |-> regRdData == 16'h0000)
    else $error("read data not cleared");
endmodule // serial_ports_chk
bind serial_ports_debug_mux serial_ports_chk chk (.*);
`default_nettype wire

/* File: dv/serial_peer.sv */
// terminal model on the far side of serial port 0
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
  input wire logic mclk,
  input wire logic txLine,
  output logic rxLine,
  output logic ctsN,
  output logic txClk,
  output logic rxClk
);
  // idle mark, not ready, clocks still
  initial begin
    rxLine = 1'b1;
    ctsN = 1'b1;
    txClk = 1'b0;
    rxClk = 1'b0;
  end
  // one frame clocked by our own receive clock, data set half a period ahead
  task automatic clkSend(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxLine <= f[i];
      repeat (8) @(posedge mclk);
      rxClk <= 1'b1;
      repeat (8) @(posedge mclk);
      rxClk <= 1'b0;
    end
  endtask
  // one 8N1 character, lsb first
  task automatic sendByte(input logic [7:0] b, input int cyc);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxLine <= f[i];
      repeat (cyc) @(posedge mclk);
    end
  endtask
  // catch a character at bit centres
  task automatic getByte(input int cyc, output logic [7:0] b);
    int n;
    n = 0;
    while (txLine !== 1'b0 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    repeat (cyc / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (cyc) @(posedge mclk);
      b[i] = txLine;
    end
  endtask
  // clock a frame out with our own transmit clock
  task automatic clkByte(output logic st, output logic [7:0] b);
    st = txLine;
    for (int i = 0; i < 9; i++) begin
      repeat (8) @(posedge mclk);
      txClk <= 1'b1;
      repeat (8) @(posedge mclk);
      txClk <= 1'b0;
      repeat (8) @(posedge mclk);
      if (i < 8) b[i] = txLine;
    end
  endtask
endmodule // serial_peer
`default_nettype wire

/* File: dv/serial_ports_debug_mux_test.sv */
// self-checking bench for the serial port block
`timescale 1ns/100ps
`default_nettype none
`include "serial_ports_regs.vh"
module serial_ports_debug_mux_test;
  logic mclk, rst, regWr, regRd, dsrN, debugStrap, dbgOut, p1Rx, p1Cts, st;
  logic p0Tx, p1Tx, p2Tx, p1Rts, dbgClk, dbgIn, p0Rx, p0Cts, extClk, rxClk;
  logic [3:0] regAddr;
  logic [15:0] regWrData, regRdData, rdVal;
  wire [4:0] gOut, gOe;
  logic [7:0] got;
  int fails, testsRun;
  serial_ports_debug_mux DUT (.mclk(mclk), .rst(rst), .ce(1'b1), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .port0_peer_ready_n(gOe[0] ? gOut[0] : dsrN),
    .port0_peer_ready_n_out(gOut[0]), .port0_peer_ready_n_oe(gOe[0]),
    .port0_terminal_ready_n(gOe[1] ? gOut[1] : 1'b1),
    .port0_terminal_ready_n_out(gOut[1]), .port0_terminal_ready_n_oe(gOe[1]),
    .port0_send_request_n(gOe[2] ? gOut[2] : 1'b1),
    .port0_send_request_n_out(gOut[2]), .port0_send_request_n_oe(gOe[2]),
    .port0_serial_in(gOe[3] ? gOut[3] : p0Rx),
    .port0_serial_in_out(gOut[3]), .port0_serial_in_oe(gOe[3]),
    .port0_clear_to_send_n(gOe[4] ? gOut[4] : p0Cts),
    .port0_clear_to_send_n_out(gOut[4]), .port0_clear_to_send_n_oe(gOe[4]),
    .port0_serial_out(p0Tx), .port1_serial_in(p1Rx), .port1_serial_out(p1Tx),
    .port1_clear_to_send_n(p1Cts), .port1_send_request_n(p1Rts),
    .port2_serial_in(1'b1), .port2_serial_out(p2Tx), .ext_transmit_bit_clock(extClk),
    .ext_receive_bit_clock(rxClk), .debugStrap(debugStrap), .debug_port_clock_in(dbgClk),
    .debug_port_serial_in(dbgIn), .debug_port_serial_out(dbgOut));
  serial_peer peer (.mclk(mclk), .txLine(p0Tx), .rxLine(p0Rx), .ctsN(p0Cts), .txClk(extClk),
    .rxClk(rxClk));
  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    testsRun++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 rdVal = regRdData;
  endtask
  task automatic doReset(input logic strap);
    debugStrap <= strap;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
  endtask
  task automatic t_idle;
    #1 chk({12'h000, p0Tx, p1Tx, p2Tx, p1Rts}, 16'h000F);
    chk({11'h000, gOe}, 16'h0006);
    chk({14'h0000, gOut[2:1]}, 16'h0003);
    rd(`REG_BAUD);
    chk(rdVal, 16'h0036);
    rd(`REG_DEBUG_SEL);
    chk(rdVal, 16'h0000);
    $display("end idle");
  endtask
  task automatic t_cmd;
    wr(`REG_COMMAND, 16'h0058);
    repeat (3) @(posedge mclk);
    #1 chk({13'h0000, gOut[2:1], p1Rts}, 16'h0000);
    wr(`REG_COMMAND, 16'h0000);
    repeat (3) @(posedge mclk);
    #1 chk({13'h0000, gOut[2:1], p1Rts}, 16'h0007);
    dsrN <= 1'b0;
    repeat (3) @(posedge mclk);
    rd(`REG_STATUS0);
    chk(rdVal & 16'h0010, 16'h0000);
    dsrN <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(`REG_STATUS0);
    chk(rdVal & 16'h0010, 16'h0010);
    $display("end cmd");
  endtask
  task automatic t_serial;
    wr(`REG_BAUD, 16'h0001);
    wr(`REG_COMMAND, 16'h0001);
    wr(`REG_DATA0, 16'h00A5);
    repeat (48) @(posedge mclk);
    #1 chk({15'h0000, p0Tx}, 16'h0001);
    peer.ctsN <= 1'b0;
    peer.getByte(16, got);
    chk({8'h00, got}, 16'h00A5);
    peer.sendByte(8'h3C, 16);
    repeat (40) @(posedge mclk);
    rd(`REG_STATUS0);
    chk(rdVal & 16'h0001, 16'h0001);
    rd(`REG_DATA0);
    chk(rdVal & 16'h00FF, 16'h003C);
    peer.rxLine <= 1'b0;
    repeat (3) @(posedge mclk);
    peer.rxLine <= 1'b1;
    repeat (200) @(posedge mclk);
    rd(`REG_STATUS0);
    chk(rdVal & 16'h0001, 16'h0000);
    $display("end serial");
  endtask
  task automatic t_gpio;
    wr(`REG_GP_MODE, 16'h0002);
    wr(`REG_GPIO_OE, 16'h001F);
    wr(`REG_GPIO_OUT, 16'h000A);
    repeat (4) @(posedge mclk);
    #1 chk({11'h000, gOe}, 16'h001F);
    chk({11'h000, gOut}, 16'h000A);
    rd(`REG_GPIO_IN);
    chk(rdVal & 16'h001F, 16'h000A);
    wr(`REG_GP_MODE, 16'h0000);
    wr(`REG_GPIO_OE, 16'h0000);
    $display("end gpio");
  endtask
  task automatic t_enh;
    int n;
    wr(`REG_COMMAND, 16'h0081);
    wr(`REG_DATA0, 16'h0096);
    for (n = 0; n < 50 && p0Tx !== 1'b0; n++) @(posedge mclk);
    peer.clkByte(st, got);
    chk({7'h00, st, got}, 16'h0096);
    peer.clkSend(8'h69);
    repeat (4) @(posedge mclk);
    rd(`REG_DATA0);
    chk(rdVal & 16'h00FF, 16'h0069);
    wr(`REG_COMMAND, 16'h0000);
    $display("end enhanced");
  endtask
  task automatic t_dbg;
    doReset(1'b0);
    for (int i = 0; i < 12; i++) begin
      @(posedge mclk);
      p1Cts <= i[0];
      p1Rx <= i[1];
      dbgOut <= i[2];
    end
    repeat (4) @(posedge mclk);
    #1 chk({13'h0000, dbgClk, dbgIn, p1Tx}, 16'h0006);
    dbgOut <= 1'b1;
    $display("end debug");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    wrap_up;
  end
  // main sequence
  initial begin
    {rst, regWr, regRd, regAddr, regWrData} = {1'b1, 22'h000000};
    {dsrN, debugStrap, dbgOut, p1Rx, p1Cts} = 5'h1F;
    doReset(1'b1);
    t_idle;
    t_cmd;
    t_serial;
    t_gpio;
    t_enh;
    t_dbg;
    wrap_up;
  end
endmodule // serial_ports_debug_mux_test
`default_nettype wire
